/* design/axu_pkg.sv */
// Shared constants and types for the execution unit
package axu_pkg;

	// ==========================================================
	// Widths
	localparam int PC_W = 24;

	// ==========================================================
	// Flag register bit positions
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;
	localparam int FLG_I = 7;
	localparam logic [7:0] FLAGS_RST = 8'h00;

	// ==========================================================
	// Flag update masks
	localparam logic [7:0] M_ARITH = 8'h2F;
	localparam logic [7:0] M_WORD = 8'h1F;
	localparam logic [7:0] M_LOGIC = 8'h0E;
	localparam logic [7:0] M_COMPL = 8'h0F;
	localparam logic [7:0] M_MUL = 8'h03;
	localparam logic [7:0] M_IRET = 8'h80;
	localparam logic [7:0] M_NONE = 8'h00;

	// ==========================================================
	// Cycle counts
	localparam logic [2:0] CYC_BASIC = 3'h1;
	localparam logic [2:0] CYC_WORD = 3'h2;
	localparam logic [2:0] CYC_MUL = 3'h2;
	localparam logic [2:0] CYC_JUMP = 3'h2;
	localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
	localparam logic [2:0] CYC_CALL = 3'h4;
	localparam logic [2:0] CYC_ABS_CALL = 3'h5;
	localparam logic [2:0] CYC_RET = 3'h5;
	localparam logic [2:0] CYC_TAKEN = 3'h2;
	localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

	// ==========================================================
	// Operations
	typedef enum logic [5:0] {
		op_add, op_add_carry, op_word_immediate_sum,
		op_sub, op_difference_constant, op_difference_with_borrow,
		op_difference_constant_borrow, op_word_immediate_difference,
		op_and, op_or, op_exclusive_or_registers, op_ones_complement,
		op_arithmetic_invert, op_mask_set_bits, op_mask_clear_bits,
		op_inc, op_dec, op_zero_sign_check, op_zero_register, op_all_ones_load,
		op_product_unsigned, op_product_signed, op_product_mixed,
		op_fraction_product_unsigned, op_fraction_product_signed,
		op_fraction_product_mixed,
		op_relative_branch_always, op_pointer_jump, op_extended_pointer_jump,
		op_absolute_branch, op_relative_subroutine_entry,
		op_pointer_subroutine_entry, op_extended_pointer_subroutine_entry,
		op_absolute_call, op_subroutine_exit, op_interrupt_exit,
		op_equal_skip, op_compare_regs, op_compare_regs_borrow,
		op_compare_immediate, op_register_bit_clear_skip,
		op_register_bit_set_skip, op_io_bit_clear_skip, op_io_bit_set_skip,
		op_flag_set_branch, op_flag_clear_branch, op_signed_ge_branch,
		op_signed_less_branch, op_unsigned_hs_branch, op_unsigned_lower_branch,
		op_nop
	} axu_op_t;

	typedef enum logic {
		st_idle,
		st_run
	} axu_state_t;

endpackage : axu_pkg

/* design/axu_as_if.sv */
// Connection between the sequencer and the byte adder
`timescale 1ns/1ps
interface axu_as_if;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic sub;
	logic [7:0] r;
	logic c;
	logic v;
	logic h;

	modport user (
		output a,
		output b,
		output cin,
		output sub,
		input r,
		input c,
		input v,
		input h
	);

	modport unit (
		input a,
		input b,
		input cin,
		input sub,
		output r,
		output c,
		output v,
		output h
	);
endinterface : axu_as_if

/* design/axu_addsub.sv */
// Byte adder and subtractor with carry, overflow and half carry
`timescale 1ns/1ps
module axu_addsub (
	axu_as_if.unit s
);
	import axu_pkg::*;

	// ==========================================================
	// Full and nibble sums
	wire [8:0] full_sum = {1'b0, s.a} + {1'b0, s.b} + {8'h00, s.cin};
	wire [8:0] full_dif = {1'b0, s.a} - {1'b0, s.b} - {8'h00, s.cin};
	wire [4:0] half_sum = {1'b0, s.a[3:0]} + {1'b0, s.b[3:0]} + {4'h0, s.cin};
	wire [4:0] half_dif = {1'b0, s.a[3:0]} - {1'b0, s.b[3:0]} - {4'h0, s.cin};
	wire [8:0] full = s.sub ? full_dif : full_sum;
	wire [4:0] half = s.sub ? half_dif : half_sum;
	wire a7 = s.a[7];
	wire b7 = s.b[7];
	wire r7 = full[7];
	wire v_add = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
	wire v_sub = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);

	// ==========================================================
	// Results
	assign s.r = full[7:0];
	assign s.c = full[8];
	assign s.h = half[4];
	assign s.v = s.sub ? v_sub : v_add;
endmodule : axu_addsub

/* design/axu_exec.sv */
// Execution unit for arithmetic, logic, multiply, jump, call, compare, skip and branch
`timescale 1ns/1ps
// Summary of operation
// - Add with or without carry, ZCNVH flags
// - Word add immediate, ZCNVS flags, two cycles
// - Subtract, borrow only in carry forms, ZCNVH
// - Word subtract immediate, ZCNVS, two cycles
// - AND OR XOR update ZNV only
// - Complement ZCNV; negate adds half carry
// - Mask clear ANDs inverse; set ORs mask
// - Inc dec test clear ZNV; ones none
// - Products into pair one zero, ZC
// - Fractional products shifted left, ZC, two
// - Relative, pointer jumps two; absolute three
// - Extended targets prefix extension register; jump two, call four
// - Calls four or five, save first
// - Compares set flags, store nothing
// - Equal skip, one two or three
// - Register bit skip, one two three
// - I/O bit skip, one two three
// - Flag index branch, one or two
// - Signed branches use N xor V
// - Carry branches and matching flag branches
module axu_exec (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic start,
	input wire axu_pkg::axu_op_t op,
	input wire logic [7:0] rd_val,
	input wire logic [7:0] opnd_val,
	input wire logic [15:0] word_val,
	input wire logic [15:0] z_ptr,
	input wire logic [7:0] ind_ext_val,
	input wire logic [axu_pkg::PC_W-1:0] pc_val,
	input wire logic [axu_pkg::PC_W-1:0] abs_addr,
	input wire logic [axu_pkg::PC_W-1:0] stack_pc,
	input wire logic [11:0] rel_off,
	input wire logic [2:0] bit_sel,
	input wire logic io_bit,
	input wire logic next_two_word,
	output logic ready,
	output logic done_q,
	output logic [7:0] res_q,
	output logic wr_rd_q,
	output logic [15:0] word_q,
	output logic wr_word_q,
	output logic [15:0] prod_q,
	output logic wr_prod_q,
	output logic [7:0] flags_q,
	output logic [axu_pkg::PC_W-1:0] pc_q,
	output logic pc_load_q,
	output logic [axu_pkg::PC_W-1:0] ret_addr_q,
	output logic push_q
);
	import axu_pkg::*;

	// ==========================================================
	// Decode helpers
	function automatic logic [7:0] fmask(input axu_op_t o);
		logic [7:0] m;
		m = M_NONE;
		case (o)
			op_add, op_add_carry: m = M_ARITH;
			op_sub, op_difference_constant: m = M_ARITH;
			op_difference_with_borrow, op_difference_constant_borrow: m = M_ARITH;
			op_word_immediate_sum, op_word_immediate_difference: m = M_WORD;
			op_and, op_or, op_exclusive_or_registers: m = M_LOGIC;
			op_ones_complement: m = M_COMPL;
			op_arithmetic_invert: m = M_ARITH;
			op_mask_set_bits, op_mask_clear_bits: m = M_LOGIC;
			op_inc, op_dec, op_zero_sign_check, op_zero_register: m = M_LOGIC;
			op_all_ones_load: m = M_NONE;
			op_product_unsigned, op_product_signed, op_product_mixed: m = M_MUL;
			op_fraction_product_unsigned, op_fraction_product_signed: m = M_MUL;
			op_fraction_product_mixed: m = M_MUL;
			op_compare_regs, op_compare_regs_borrow, op_compare_immediate: m = M_ARITH;
			op_interrupt_exit: m = M_IRET;
			default: m = M_NONE;
		endcase
		return m;
	endfunction : fmask

	function automatic logic [2:0] cyc_of(input axu_op_t o, input logic tk, input logic two);
		logic [2:0] c;
		c = CYC_BASIC;
		case (o)
			op_word_immediate_sum, op_word_immediate_difference: c = CYC_WORD;
			op_product_unsigned, op_product_signed, op_product_mixed: c = CYC_MUL;
			op_fraction_product_unsigned, op_fraction_product_signed: c = CYC_MUL;
			op_fraction_product_mixed: c = CYC_MUL;
			op_relative_branch_always, op_pointer_jump: c = CYC_JUMP;
			op_extended_pointer_jump: c = CYC_JUMP;
			op_absolute_branch: c = CYC_ABS_JUMP;
			op_relative_subroutine_entry, op_pointer_subroutine_entry: c = CYC_CALL;
			op_extended_pointer_subroutine_entry: c = CYC_CALL;
			op_absolute_call: c = CYC_ABS_CALL;
			op_subroutine_exit, op_interrupt_exit: c = CYC_RET;
			op_equal_skip, op_register_bit_clear_skip, op_register_bit_set_skip,
			op_io_bit_clear_skip, op_io_bit_set_skip: begin
				c = tk ? (two ? CYC_SKIP_TWO : CYC_SKIP_ONE) : CYC_BASIC;
			end
			op_flag_set_branch, op_flag_clear_branch, op_signed_ge_branch,
			op_signed_less_branch, op_unsigned_hs_branch, op_unsigned_lower_branch: begin
				c = tk ? CYC_TAKEN : CYC_BASIC;
			end
			default: c = CYC_BASIC;
		endcase
		return c;
	endfunction : cyc_of

	// ==========================================================
	// Operation classes
	wire use_carry = op inside {op_add_carry, op_difference_with_borrow,
		op_difference_constant_borrow, op_compare_regs_borrow};
	wire is_sub = op inside {op_sub, op_difference_constant, op_difference_with_borrow,
		op_difference_constant_borrow, op_ones_complement, op_arithmetic_invert, op_dec,
		op_compare_regs, op_compare_regs_borrow, op_compare_immediate};
	wire is_logic = op inside {op_and, op_or, op_exclusive_or_registers, op_mask_set_bits,
		op_mask_clear_bits, op_zero_sign_check, op_zero_register, op_all_ones_load};
	wire is_byte_wr = is_logic | (op inside {op_add, op_add_carry, op_sub,
		op_difference_constant, op_difference_with_borrow, op_difference_constant_borrow,
		op_ones_complement, op_arithmetic_invert, op_inc, op_dec});
	wire is_word = op inside {op_word_immediate_sum, op_word_immediate_difference};
	wire is_frac = op inside {op_fraction_product_unsigned, op_fraction_product_signed,
		op_fraction_product_mixed};
	wire is_mul = is_frac | (op inside {op_product_unsigned, op_product_signed,
		op_product_mixed});
	wire is_call = op inside {op_relative_subroutine_entry, op_pointer_subroutine_entry,
		op_extended_pointer_subroutine_entry, op_absolute_call};
	wire is_skip = op inside {op_equal_skip, op_register_bit_clear_skip,
		op_register_bit_set_skip, op_io_bit_clear_skip, op_io_bit_set_skip};
	wire is_branch = op inside {op_flag_set_branch, op_flag_clear_branch,
		op_signed_ge_branch, op_signed_less_branch, op_unsigned_hs_branch,
		op_unsigned_lower_branch};

	// ==========================================================
	// Byte adder
	axu_as_if as_bus ();

	axu_addsub u_addsub (
		.s(as_bus.unit)
	);

	assign as_bus.a = (op == op_ones_complement) ? 8'hFF :
		(op == op_arithmetic_invert) ? 8'h00 : rd_val;
	assign as_bus.b = (op inside {op_ones_complement, op_arithmetic_invert}) ? rd_val :
		(op inside {op_inc, op_dec}) ? 8'h01 : opnd_val;
	assign as_bus.cin = use_carry & flags_q[FLG_C];
	assign as_bus.sub = is_sub;

	// ==========================================================
	// Logic unit
	wire [7:0] lg_r = (op == op_and) ? (rd_val & opnd_val) :
		(op == op_mask_clear_bits) ? (rd_val & (8'hFF - opnd_val)) :
		(op inside {op_or, op_mask_set_bits}) ? (rd_val | opnd_val) :
		(op == op_exclusive_or_registers) ? (rd_val ^ opnd_val) :
		(op == op_zero_sign_check) ? (rd_val & rd_val) :
		(op == op_zero_register) ? (rd_val ^ rd_val) : 8'hFF;
	wire [7:0] byte_r = is_logic ? lg_r : as_bus.r;

	// ==========================================================
	// Word unit
	wire w_sub = (op == op_word_immediate_difference);
	wire [15:0] wres = w_sub ? (word_val - {8'h00, opnd_val}) :
		(word_val + {8'h00, opnd_val});
	wire wv = w_sub ? (word_val[15] & ~wres[15]) : (~word_val[15] & wres[15]);
	wire wc = w_sub ? (wres[15] & ~word_val[15]) : (~wres[15] & word_val[15]);

	// ==========================================================
	// Multiplier
	wire a_sgn = op inside {op_product_signed, op_product_mixed,
		op_fraction_product_signed, op_fraction_product_mixed};
	wire b_sgn = op inside {op_product_signed, op_fraction_product_signed};
	wire signed [8:0] ma = {a_sgn & rd_val[7], rd_val};
	wire signed [8:0] mb = {b_sgn & opnd_val[7], opnd_val};
	wire signed [17:0] mp = ma * mb;
	wire [15:0] prod_r = is_frac ? {mp[14:0], 1'b0} : mp[15:0];
	wire mc = mp[15];

	// ==========================================================
	// New flag values
	wire [7:0] nf;
	assign nf[FLG_C] = is_mul ? mc : is_word ? wc : as_bus.c;
	assign nf[FLG_Z] = is_mul ? (prod_r == 16'h0000) :
		is_word ? (wres == 16'h0000) : (byte_r == 8'h00);
	assign nf[FLG_N] = is_word ? wres[15] : byte_r[7];
	assign nf[FLG_V] = is_word ? wv : is_logic ? 1'b0 : as_bus.v;
	assign nf[FLG_S] = nf[FLG_N] ^ nf[FLG_V];
	assign nf[FLG_H] = as_bus.h;
	assign nf[FLG_T] = 1'b0;
	assign nf[FLG_I] = 1'b1;
	wire [7:0] upd_mask = fmask(op);
	wire [7:0] flags_n = (flags_q & ~upd_mask) | (nf & upd_mask);

	// ==========================================================
	// Branch and skip conditions
	wire flg_sel = flags_q[bit_sel];
	wire n_xor_v = flags_q[FLG_N] ^ flags_q[FLG_V];
	wire br_take = (op == op_flag_set_branch) ? flg_sel :
		(op == op_flag_clear_branch) ? ~flg_sel :
		(op == op_signed_ge_branch) ? ~n_xor_v :
		(op == op_signed_less_branch) ? n_xor_v :
		(op == op_unsigned_hs_branch) ? ~flags_q[FLG_C] :
		(op == op_unsigned_lower_branch) ? flags_q[FLG_C] : 1'b0;
	wire sk_take = (op == op_equal_skip) ? (rd_val == opnd_val) :
		(op == op_register_bit_clear_skip) ? ~rd_val[bit_sel] :
		(op == op_register_bit_set_skip) ? rd_val[bit_sel] :
		(op == op_io_bit_clear_skip) ? ~io_bit :
		(op == op_io_bit_set_skip) ? io_bit : 1'b0;
	wire taken = (is_branch & br_take) | (is_skip & sk_take);

	// ==========================================================
	// Program counter targets
	wire [PC_W-1:0] pc_inc = pc_val + PC_W'(1);
	wire [PC_W-1:0] rel_t = pc_val + {{(PC_W - 12){rel_off[11]}}, rel_off} + PC_W'(1);
	wire [PC_W-1:0] skip_t = pc_val + (next_two_word ? PC_W'(3) : PC_W'(2));
	wire [PC_W-1:0] ptr_t = {8'h00, z_ptr};
	wire [PC_W-1:0] ext_t = {ind_ext_val, z_ptr};
	wire [PC_W-1:0] pc_n = (op inside {op_relative_branch_always,
		op_relative_subroutine_entry}) ? rel_t :
		(op inside {op_pointer_jump, op_pointer_subroutine_entry}) ? ptr_t :
		(op inside {op_extended_pointer_jump,
		op_extended_pointer_subroutine_entry}) ? ext_t :
		(op inside {op_absolute_branch, op_absolute_call}) ? abs_addr :
		(op inside {op_subroutine_exit, op_interrupt_exit}) ? stack_pc :
		(is_branch & br_take) ? rel_t :
		(is_skip & sk_take) ? skip_t : pc_inc;
	wire [PC_W-1:0] ret_n = (op == op_absolute_call) ? (pc_val + PC_W'(2)) : pc_inc;

	// ==========================================================
	// Sequencer
	axu_state_t st_q;
	axu_state_t st_d;
	logic [2:0] cnt_q;
	logic [7:0] flags_pend_q;
	logic wr_rd_pend_q;
	logic wr_word_pend_q;
	logic wr_prod_pend_q;

	wire [2:0] cyc_n = cyc_of(op, taken, next_two_word);
	wire take = start & (st_q == st_idle);
	wire fin = (take & (cyc_n == CYC_BASIC)) | ((st_q == st_run) & (cnt_q == 3'h1));
	wire idle = (st_q == st_idle);
	wire k_rd = idle ? is_byte_wr : wr_rd_pend_q;
	wire k_word = idle ? is_word : wr_word_pend_q;
	wire k_prod = idle ? is_mul : wr_prod_pend_q;
	wire [7:0] k_flags = idle ? flags_n : flags_pend_q;

	assign ready = idle;

	always_comb begin
		st_d = st_q;
		case (st_q)
			st_idle: begin
				if (take && cyc_n != CYC_BASIC) begin
					st_d = st_run;
				end
			end
			st_run: begin
				if (fin) begin
					st_d = st_idle;
				end
			end
			default: st_d = st_idle;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_q <= st_idle;
			cnt_q <= 3'h0;
		end else begin
			st_q <= st_d;
			if (take) begin
				cnt_q <= cyc_n - 3'h1;
			end else if (st_q == st_run) begin
				cnt_q <= cnt_q - 3'h1;
			end
		end
	end

	// ==========================================================
	// Result capture at start
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			res_q <= 8'h00;
			word_q <= 16'h0000;
			prod_q <= 16'h0000;
			pc_q <= '0;
			ret_addr_q <= '0;
			flags_pend_q <= FLAGS_RST;
			wr_rd_pend_q <= 1'b0;
			wr_word_pend_q <= 1'b0;
			wr_prod_pend_q <= 1'b0;
		end else if (take) begin
			res_q <= byte_r;
			word_q <= wres;
			prod_q <= prod_r;
			pc_q <= pc_n;
			ret_addr_q <= ret_n;
			flags_pend_q <= flags_n;
			wr_rd_pend_q <= is_byte_wr;
			wr_word_pend_q <= is_word;
			wr_prod_pend_q <= is_mul;
		end
	end

	// ==========================================================
	// Completion strobes and flag register
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			done_q <= 1'b0;
			wr_rd_q <= 1'b0;
			wr_word_q <= 1'b0;
			wr_prod_q <= 1'b0;
			pc_load_q <= 1'b0;
			push_q <= 1'b0;
			flags_q <= FLAGS_RST;
		end else begin
			done_q <= fin;
			wr_rd_q <= fin & k_rd;
			wr_word_q <= fin & k_word;
			wr_prod_q <= fin & k_prod;
			pc_load_q <= fin;
			push_q <= take & is_call;
			if (fin) begin
				flags_q <= k_flags;
			end
		end
	end
endmodule : axu_exec

/* tb/axu_exec_asserts.sv */
// Concurrent checks on the execution unit ports
`timescale 1ns/1ps
module axu_exec_asserts (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic start,
	input wire axu_pkg::axu_op_t op,
	input wire logic [7:0] rd_val,
	input wire logic [7:0] opnd_val,
	input wire logic [15:0] z_ptr,
	input wire logic [7:0] ind_ext_val,
	input wire logic [axu_pkg::PC_W-1:0] pc_val,
	input wire logic [axu_pkg::PC_W-1:0] abs_addr,
	input wire logic [axu_pkg::PC_W-1:0] stack_pc,
	input wire logic next_two_word,
	input wire logic ready,
	input wire logic done_q,
	input wire logic [7:0] res_q,
	input wire logic wr_rd_q,
	input wire logic wr_word_q,
	input wire logic [15:0] prod_q,
	input wire logic wr_prod_q,
	input wire logic [7:0] flags_q,
	input wire logic [axu_pkg::PC_W-1:0] pc_q,
	input wire logic pc_load_q,
	input wire logic push_q
);
	import axu_pkg::*;
	wire take = start && ready;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	// ==========================================================
	// Timing and flags
	AST_ADD_ONE: assert property (take && op inside {op_add, op_add_carry} |=> done_q && wr_rd_q && ready)
		else $error("add did not finish in one cycle");
	AST_WORD_TWO: assert property (take && op inside {op_word_immediate_sum,
		op_word_immediate_difference} |=> !done_q && !ready ##1 done_q && wr_word_q)
		else $error("word op not two cycles");
	AST_LOGIC_KEEP_C: assert property (take && op inside {op_and, op_or, op_exclusive_or_registers}
		|=> done_q && flags_q[FLG_C] == $past(flags_q[FLG_C]))
		else $error("logic op changed carry");
	AST_ONES_FLAGS: assert property (take && op == op_all_ones_load |=> res_q == 8'hFF && $stable(flags_q))
		else $error("all ones load wrong");
	AST_MUL_TWO: assert property (take && op inside {op_product_unsigned, op_product_signed,
		op_product_mixed, op_fraction_product_unsigned, op_fraction_product_signed, op_fraction_product_mixed}
		|=> !done_q ##1 done_q && wr_prod_q && flags_q[FLG_Z] == (prod_q == 16'h0000))
		else $error("multiply timing or zero flag wrong");
	AST_CMP_NOSTORE: assert property (take && op inside {op_compare_regs, op_compare_regs_borrow,
		op_compare_immediate} |=> done_q && !wr_rd_q)
		else $error("compare stored a result");

	// ==========================================================
	// Program flow
	AST_ABS_JUMP: assert property (take && op == op_absolute_branch
		|=> !done_q [*2] ##1 done_q && pc_q == $past(abs_addr, 3))
		else $error("absolute jump wrong");
	AST_EXT_TARGET: assert property (take && op inside {op_extended_pointer_jump,
		op_extended_pointer_subroutine_entry} |=> pc_q == {$past(ind_ext_val), $past(z_ptr)})
		else $error("extended target wrong");
	AST_CALL_FOUR: assert property (take && op inside {op_relative_subroutine_entry,
		op_pointer_subroutine_entry, op_extended_pointer_subroutine_entry}
		|=> push_q && !done_q ##1 !done_q [*2] ##1 done_q)
		else $error("call not four cycles");
	AST_ABS_CALL: assert property (take && op == op_absolute_call
		|=> push_q && !done_q ##1 !done_q [*3] ##1 done_q && pc_load_q)
		else $error("absolute call not five cycles");
	AST_RET_FIVE: assert property (take && op inside {op_subroutine_exit, op_interrupt_exit}
		|=> pc_q == $past(stack_pc) && !done_q ##1 !done_q [*3] ##1 done_q)
		else $error("return wrong");
	AST_IRET_I: assert property (take && op == op_interrupt_exit |-> ##5 flags_q[FLG_I])
		else $error("interrupt exit left I clear");
	AST_SIGNED_LT: assert property (take && op == op_signed_less_branch && (flags_q[FLG_N] ^ flags_q[FLG_V])
		|=> !done_q ##1 done_q)
		else $error("signed less branch not taken");
	AST_EQ_SKIP: assert property (take && op == op_equal_skip && rd_val == opnd_val && !next_two_word
		|=> !done_q && pc_q == $past(pc_val) + 24'h000002 ##1 done_q)
		else $error("equal skip wrong");
endmodule : axu_exec_asserts

bind axu_exec axu_exec_asserts u_chk (.clk_sys(clk_sys), .nrst(nrst), .start(start), .op(op), .rd_val(rd_val),
	.opnd_val(opnd_val), .z_ptr(z_ptr), .ind_ext_val(ind_ext_val), .pc_val(pc_val), .abs_addr(abs_addr),
	.stack_pc(stack_pc), .next_two_word(next_two_word), .ready(ready), .done_q(done_q), .res_q(res_q),
	.wr_rd_q(wr_rd_q), .wr_word_q(wr_word_q), .prod_q(prod_q), .wr_prod_q(wr_prod_q), .flags_q(flags_q),
	.pc_q(pc_q), .pc_load_q(pc_load_q), .push_q(push_q));

/* tb/tb_alu_and_branch_execution.sv */
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module tb_alu_and_branch_execution;
	import axu_pkg::*;
	typedef struct {axu_op_t op; logic [15:0] ab; logic [7:0] ctl; logic [15:0] mf; logic [23:0] r; int c; int s;} axu_row_t;
	logic clk_sys = 1'b0, nrst = 1'b0, start = 1'b0, io_bit = 1'b0, next_two_word = 1'b0;
	axu_op_t op = op_nop;
	logic [7:0] rd_val = 8'h00, opnd_val = 8'h00, ind_ext_val = 8'h05;
	logic [2:0] bit_sel = 3'h0;
	logic [15:0] word_val = 16'h0000, z_ptr = 16'h1234;
	logic [23:0] pc_val = 24'h000100, abs_addr = 24'h00ABCD, stack_pc = 24'h000456;
	logic [11:0] rel_off = 12'hFFE;
	logic ready, done_q, wr_rd_q, wr_word_q, wr_prod_q, pc_load_q, push_q;
	logic [7:0] res_q, flags_q;
	logic [15:0] word_q, prod_q;
	logic [23:0] pc_q, ret_addr_q;
	int n_errors = 0, n_compared = 0;
	axu_row_t rows [0:57] = '{
		'{op_add,16'h0F01,8'h00,16'h2F20,24'h10,1,0}, '{op_add,16'hFF01,8'h00,16'h2F23,24'h0,1,0},
		'{op_add_carry,16'h1020,8'h00,16'h2F00,24'h31,1,0}, '{op_sub,16'h0001,8'h00,16'h2F25,24'hFF,1,0},
		'{op_difference_with_borrow,16'h0502,8'h00,16'h2F00,24'h2,1,0},
		'{op_difference_constant_borrow,16'h0502,8'h00,16'h2F00,24'h3,1,0},
		'{op_compare_immediate,16'h0102,8'h00,16'h2F25,24'h0,1,4},
		'{op_difference_constant,16'h0502,8'h00,16'h2F00,24'h3,1,0},
		'{op_compare_immediate,16'h0102,8'h00,16'h2F25,24'h0,1,4},
		'{op_compare_regs_borrow,16'h0504,8'h00,16'h2F02,24'h0,1,4},
		'{op_compare_regs,16'h0505,8'h00,16'h2F02,24'h0,1,4},
		'{op_compare_immediate,16'h0102,8'h00,16'h2F25,24'h0,1,4}, '{op_and,16'hF080,8'h00,16'h0F05,24'h80,1,0},
		'{op_or,16'h0000,8'h00,16'h0F03,24'h0,1,0}, '{op_exclusive_or_registers,16'hAA55,8'h00,16'h0F05,24'hFF,1,0},
		'{op_mask_clear_bits,16'hFF0F,8'h00,16'h0F05,24'hF0,1,0}, '{op_mask_set_bits,16'h0180,8'h00,16'h0F05,24'h81,1,0},
		'{op_zero_sign_check,16'h0000,8'h00,16'h0F03,24'h0,1,0}, '{op_zero_register,16'h5A5A,8'h00,16'h0F03,24'h0,1,0},
		'{op_inc,16'h0000,8'h00,16'h0F01,24'h1,1,0}, '{op_dec,16'h0100,8'h00,16'h0F03,24'h0,1,0},
		'{op_all_ones_load,16'h0000,8'h00,16'h0F03,24'hFF,1,0}, '{op_ones_complement,16'h5500,8'h00,16'h0F04,24'hAA,1,0},
		'{op_arithmetic_invert,16'h0100,8'h00,16'h2F25,24'hFF,1,0},
		'{op_product_unsigned,16'hFFFF,8'h00,16'h0301,24'hFE01,2,1},
		'{op_product_signed,16'hFF02,8'h00,16'h0301,24'hFFFE,2,1},
		'{op_product_mixed,16'hFF02,8'h00,16'h0301,24'hFFFE,2,1},
		'{op_fraction_product_unsigned,16'h8080,8'h00,16'h0300,24'h8000,2,1},
		'{op_fraction_product_signed,16'h4040,8'h00,16'h0300,24'h2000,2,1},
		'{op_fraction_product_mixed,16'hC040,8'h00,16'h0301,24'hE000,2,1},
		'{op_word_immediate_sum,16'h0001,8'hFF,16'h1F00,24'h0100,2,3},
		'{op_word_immediate_difference,16'h0001,8'h00,16'h1F15,24'hFFFF,2,3},
		'{op_word_immediate_sum,16'hFF01,8'hFF,16'h1F03,24'h0,2,3},
		'{op_relative_branch_always,16'h0,8'h00,16'h0,24'hFF,2,2}, '{op_pointer_jump,16'h0,8'h00,16'h0,24'h1234,2,2},
		'{op_extended_pointer_jump,16'h0,8'h00,16'h0,24'h51234,2,2}, '{op_absolute_branch,16'h0,8'h00,16'h0,24'hABCD,3,2},
		'{op_relative_subroutine_entry,16'h0,8'h00,16'h0,24'hFF,4,2},
		'{op_pointer_subroutine_entry,16'h0,8'h00,16'h0,24'h1234,4,2},
		'{op_extended_pointer_subroutine_entry,16'h0,8'h00,16'h0,24'h51234,4,2},
		'{op_absolute_call,16'h0,8'h00,16'h0,24'hABCD,5,2}, '{op_subroutine_exit,16'h0,8'h00,16'h0,24'h456,5,2},
		'{op_interrupt_exit,16'h0,8'h00,16'h8080,24'h456,5,2}, '{op_sub,16'h0001,8'h00,16'h2F25,24'hFF,1,0},
		'{op_flag_set_branch,16'h0,8'h00,16'hFFA5,24'h211,2,2}, '{op_flag_clear_branch,16'h0,8'h00,16'hFFA5,24'h201,1,2},
		'{op_flag_set_branch,16'h0,8'h01,16'h0,24'h201,1,2}, '{op_signed_less_branch,16'h0,8'h00,16'h0,24'h211,2,2},
		'{op_signed_ge_branch,16'h0,8'h00,16'h0,24'h201,1,2}, '{op_unsigned_lower_branch,16'h0,8'h00,16'h0,24'h211,2,2},
		'{op_unsigned_hs_branch,16'h0,8'h00,16'h0,24'h201,1,2},
		'{op_equal_skip,16'h0505,8'h00,16'hFFA5,24'h202,2,2}, '{op_equal_skip,16'h0506,8'h00,16'hFFA5,24'h201,1,2},
		'{op_equal_skip,16'h0505,8'h10,16'h0,24'h203,3,2}, '{op_register_bit_clear_skip,16'h0800,8'h03,16'h0,24'h201,1,2},
		'{op_register_bit_set_skip,16'h0800,8'h13,16'h0,24'h203,3,2},
		'{op_io_bit_clear_skip,16'h0,8'h00,16'h0,24'h202,2,2}, '{op_io_bit_set_skip,16'h0,8'h08,16'h0,24'h202,2,2}};

	always #2.5 clk_sys = ~clk_sys;

	axu_exec DUT (.clk_sys(clk_sys), .nrst(nrst), .start(start), .op(op), .rd_val(rd_val), .opnd_val(opnd_val),
		.word_val(word_val), .z_ptr(z_ptr), .ind_ext_val(ind_ext_val), .pc_val(pc_val), .abs_addr(abs_addr),
		.stack_pc(stack_pc), .rel_off(rel_off), .bit_sel(bit_sel), .io_bit(io_bit), .next_two_word(next_two_word),
		.ready(ready), .done_q(done_q), .res_q(res_q), .wr_rd_q(wr_rd_q), .word_q(word_q), .wr_word_q(wr_word_q),
		.prod_q(prod_q), .wr_prod_q(wr_prod_q), .flags_q(flags_q), .pc_q(pc_q), .pc_load_q(pc_load_q),
		.ret_addr_q(ret_addr_q), .push_q(push_q));

	// ==========================================================
	// Compare and drive
	task automatic chk_data(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk_data

	task automatic chk_cyc(input int got, input int exp);
		n_compared++;
		if (got != exp) begin
			n_errors++;
			$display("ERROR at %0t: cycles got %0h expected %0h", $time, got, exp);
		end
	endtask : chk_cyc

	task automatic run_row(input int i);
		axu_row_t w;
		int n;
		logic [23:0] got;
		w = rows[i];
		@(negedge clk_sys);
		op = w.op;
		{rd_val, opnd_val} = w.ab;
		word_val = {w.ab[15:8], w.ctl};
		{next_two_word, io_bit, bit_sel} = w.ctl[4:0];
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		n = 1;
		while (done_q !== 1'b1 && n < 8) begin
			@(negedge clk_sys);
			n++;
		end
		case (w.s)
			0: got = 24'(res_q);
			1: got = 24'(prod_q);
			2: got = pc_q;
			3: got = 24'(word_q);
			default: got = 24'(wr_rd_q);
		endcase
		chk_cyc(n, w.c);
		chk_data(got, w.r);
		chk_data(24'(flags_q & w.mf[15:8]), 24'(w.mf[7:0]));
		if (i >= 37 && i <= 40) chk_data(ret_addr_q, (i == 40) ? 24'h000102 : 24'h000101);
	endtask : run_row

	// ==========================================================
	// Scenarios
	task automatic t_arith();
		for (int i = 0; i <= 10; i++) run_row(i);
	endtask : t_arith

	task automatic t_logic();
		for (int i = 11; i <= 23; i++) run_row(i);
	endtask : t_logic

	task automatic t_mul_word();
		for (int i = 24; i <= 32; i++) run_row(i);
	endtask : t_mul_word

	task automatic t_flow();
		for (int i = 33; i <= 42; i++) run_row(i);
	endtask : t_flow

	task automatic t_branch_skip();
		pc_val = 24'h000200;
		rel_off = 12'h010;
		for (int i = 43; i <= 57; i++) run_row(i);
	endtask : t_branch_skip

	task automatic report_and_stop();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#20000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		repeat (5) @(negedge clk_sys);
		nrst = 1'b1;
		@(negedge clk_sys);
		chk_data(24'(flags_q), 24'h000000);
		chk_data(24'(ready), 24'h000001);
		t_arith();
		t_logic();
		t_mul_word();
		t_flow();
		t_branch_skip();
		report_and_stop();
	end
endmodule : tb_alu_and_branch_execution
